// >>> ccrb_codec_control_register_bank.sv
`timescale 1ns/1ps
// Behaviour
// - four 16-bit program words; each complete word lands in exactly one
// - bits 10..9 select left, right, general or format word
// - gain words: bit 8 load control, bits 7..0 attenuation code
// - attenuation code bit 7 is msb, bit 0 is lsb
// - load bit 1 makes output level follow the new code
// - load bit 0 keeps previous applied level, new code held pending
// - any load applies both pending channel codes together
// - gain 20log10(code/256); 00h mute, ffh 0 dB and reset default
// - general word field positions bits 8..0 as documented
// - format word: loopback bit 5, format bits 3..2, polarity bit 1
// - control arrives on shift clock, serial data and latch strobe
// - shared gain mode drives both channels from the left code
// - soft silence ramps both channel levels down together, click-free
`include "ccrb_params.svh"
module ccrb_codec_control_register_bank (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial control link
  input wire logic control_shift_clock,
  input wire logic control_serial_data,
  input wire logic latch_strobe,
  // applied controls
  output ccrb_pkg::ccrb_gain_s gain_out,
  output ccrb_pkg::ccrb_ctrl_s ctrl_out,
  output logic word_taken
);
  import ccrb_pkg::*;
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] sck_sync_reg, sda_sync_reg, stb_sync_reg;
  logic sck_prev_reg, stb_prev_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      sck_sync_reg <= 2'h0;
      sda_sync_reg <= 2'h0;
      stb_sync_reg <= 2'h0;
      sck_prev_reg <= 1'b0;
      stb_prev_reg <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], control_shift_clock};
      sda_sync_reg <= {sda_sync_reg[0], control_serial_data};
      stb_sync_reg <= {stb_sync_reg[0], latch_strobe};
      sck_prev_reg <= sck_sync_reg[1];
      stb_prev_reg <= stb_sync_reg[1];
    end
  end
  wire sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
  wire stb_rise = stb_sync_reg[1] & ~stb_prev_reg;
  // ****************************************
  // shifter, msb first
  // ****************************************
  logic [15:0] shift_reg;
  logic [4:0] count_reg;
  wire [4:0] word_len = 5'(`CCRB_WORD_BITS);
  wire [4:0] count_next = (count_reg == word_len) ? count_reg : count_reg + 5'h1;
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_reg <= 16'h0;
      count_reg <= 5'h0;
    end else if (stb_rise) begin
      count_reg <= 5'h0;
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[14:0], sda_sync_reg[1]};
      count_reg <= count_next;
    end
  end
  // short words are dropped rather than written half-formed
  wire word_done = stb_rise & (count_reg == word_len);
  wire [1:0] sel = shift_reg[`CCRB_SEL_HI:`CCRB_SEL_LO];
  wire wr_left = word_done & (sel == `CCRB_SEL_LEFT);
  wire wr_right = word_done & (sel == `CCRB_SEL_RIGHT);
  wire wr_general = word_done & (sel == `CCRB_SEL_GENERAL);
  wire wr_format = word_done & (sel == `CCRB_SEL_FORMAT);
  // ****************************************
  // program words
  // ****************************************
  logic [15:0] left_gain_word_reg, right_gain_word_reg;
  logic [15:0] general_control_word_reg, format_word_reg;
  // reserved bits are stored as sent; host keeps them zero
  always_ff @(posedge clk) begin
    if (reset) begin
      left_gain_word_reg <= `CCRB_LEFT_RESET;
      right_gain_word_reg <= `CCRB_RIGHT_RESET;
      general_control_word_reg <= `CCRB_GENERAL_RESET;
      format_word_reg <= `CCRB_FORMAT_RESET;
    end else begin
      if (wr_left) left_gain_word_reg <= shift_reg;
      if (wr_right) right_gain_word_reg <= shift_reg;
      if (wr_general) general_control_word_reg <= shift_reg;
      if (wr_format) format_word_reg <= shift_reg;
    end
  end
  // ****************************************
  // gain apply
  // ****************************************
  wire [7:0] left_code = left_gain_word_reg[`CCRB_CODE_HI:`CCRB_CODE_LO];
  wire [7:0] right_code = right_gain_word_reg[`CCRB_CODE_HI:`CCRB_CODE_LO];
  wire [7:0] new_left = wr_left ? shift_reg[`CCRB_CODE_HI:`CCRB_CODE_LO] : left_code;
  wire [7:0] new_right = wr_right ? shift_reg[`CCRB_CODE_HI:`CCRB_CODE_LO] : right_code;
  wire load_now = (wr_left | wr_right) & shift_reg[`CCRB_LOAD_BIT];
  wire shared = general_control_word_reg[`CCRB_SHARED_BIT];
  logic [7:0] app_left_reg, app_right_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      app_left_reg <= `CCRB_GAIN_RESET;
      app_right_reg <= `CCRB_GAIN_RESET;
    end else if (load_now) begin
      app_left_reg <= new_left;
      app_right_reg <= new_right;
    end
  end
  // ****************************************
  // soft silence ramp
  // ****************************************
  // the tick runs free, so a mute request waits at most one step period
  logic [7:0] ramp_reg;
  logic [8:0] tick_reg;
  wire silence = general_control_word_reg[`CCRB_SILENCE_BIT];
  wire tick = (tick_reg == 9'(`CCRB_RAMP_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (reset) begin
      ramp_reg <= 8'hff;
      tick_reg <= 9'h0;
    end else begin
      tick_reg <= tick ? 9'h0 : tick_reg + 9'h1;
      if (tick & silence & (ramp_reg != 8'h0)) ramp_reg <= ramp_reg - 8'h1;
      else if (tick & ~silence & (ramp_reg != 8'hff)) ramp_reg <= ramp_reg + 8'h1;
    end
  end
  // levels are capped by the ramp, so a load during silence never jumps above it
  wire [7:0] eff_left = app_left_reg;
  wire [7:0] eff_right = shared ? app_left_reg : app_right_reg;
  wire [7:0] lim_left = (eff_left < ramp_reg) ? eff_left : ramp_reg;
  wire [7:0] lim_right = (eff_right < ramp_reg) ? eff_right : ramp_reg;
  // ****************************************
  // outputs from flip-flops
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      gain_out <= '{left_level: `CCRB_GAIN_RESET, right_level: `CCRB_GAIN_RESET};
      ctrl_out <= `CCRB_CTRL_RESET;
      word_taken <= 1'b0;
    end else begin
      gain_out.left_level <= lim_left;
      gain_out.right_level <= lim_right;
      word_taken <= word_done;
      ctrl_out.adc_power_down <= general_control_word_reg[`CCRB_ADC_PD_BIT];
      ctrl_out.hpf_skip <= general_control_word_reg[`CCRB_HPF_SKIP_BIT];
      ctrl_out.dac_power_down <= general_control_word_reg[`CCRB_DAC_PD_BIT];
      ctrl_out.shared_gain_mode <= shared;
      ctrl_out.zero_detect_enable <= general_control_word_reg[`CCRB_ZERO_DET_BIT];
      ctrl_out.output_disable <= general_control_word_reg[`CCRB_OUT_DIS_BIT];
      ctrl_out.deemphasis_select <=
        general_control_word_reg[`CCRB_DEEMPH_HI:`CCRB_DEEMPH_LO];
      ctrl_out.soft_silence <= silence;
      ctrl_out.loopback_enable <= format_word_reg[`CCRB_LOOPBACK_BIT];
      ctrl_out.audio_format <= format_word_reg[`CCRB_FMT_HI:`CCRB_FMT_LO];
      ctrl_out.frame_polarity <= format_word_reg[`CCRB_POLARITY_BIT];
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_word_taken_pulse: assert property (word_done |=> word_taken)
    else $error("word_taken missing after complete word");
  a_short_word_drop: assert property (stb_rise && count_reg != word_len |=>
    !word_taken)
    else $error("short word accepted");
  a_one_target_only: assert property (
    $onehot0({wr_left, wr_right, wr_general, wr_format}))
    else $error("word written to more than one register");
  a_select_decode: assert property (word_done && sel == `CCRB_SEL_GENERAL |=>
    general_control_word_reg == $past(shift_reg))
    else $error("general word not written on select 10");
  a_hold_no_load: assert property (word_done && !shift_reg[`CCRB_LOAD_BIT] |=>
    $stable(app_left_reg) && $stable(app_right_reg))
    else $error("level applied without load bit");
  a_load_follows: assert property (wr_left && shift_reg[`CCRB_LOAD_BIT] |=>
    app_left_reg == $past(shift_reg[`CCRB_CODE_HI:`CCRB_CODE_LO]))
    else $error("left level did not follow loaded code");
  a_right_follows: assert property (wr_right && shift_reg[`CCRB_LOAD_BIT] |=>
    app_right_reg == $past(shift_reg[`CCRB_CODE_HI:`CCRB_CODE_LO]))
    else $error("right level did not follow loaded code");
  a_both_apply: assert property (wr_right && shift_reg[`CCRB_LOAD_BIT] |=>
    app_left_reg == $past(left_code))
    else $error("left pending code not applied with right load");
  a_both_from_left: assert property (wr_left && shift_reg[`CCRB_LOAD_BIT] |=>
    app_right_reg == $past(right_code))
    else $error("right pending code not applied with left load");
  a_shared_gain: assert property (shared && ramp_reg == 8'hff |=>
    gain_out.right_level == $past(app_left_reg))
    else $error("shared mode did not copy left code");
  a_mute_code: assert property (app_right_reg == 8'h0 && !shared |=>
    gain_out.right_level == 8'h0)
    else $error("code 00 did not mute the channel");
  a_silence_floor: assert property (silence && ramp_reg == 8'h0 |=>
    gain_out.left_level == 8'h0 && gain_out.right_level == 8'h0)
    else $error("silence did not reach mute");
  // one code per step keeps every ramp-driven level change small, so mute is click-free
  a_ramp_step: assert property (!$stable(ramp_reg) |->
    8'($past(ramp_reg) - ramp_reg) == 8'h1 || 8'(ramp_reg - $past(ramp_reg)) == 8'h1)
    else $error("silence ramp jumped by more than one code");
  a_format_fields: assert property (wr_format |=> ##1
    ctrl_out.audio_format == $past(shift_reg[`CCRB_FMT_HI:`CCRB_FMT_LO], 2))
    else $error("format field misplaced");
  a_silence_field: assert property (wr_general |=> ##1
    ctrl_out.soft_silence == $past(shift_reg[`CCRB_SILENCE_BIT], 2))
    else $error("soft silence field misplaced");
  // ****************************************
  // cover points
  // ****************************************
  c_left_load: cover property (wr_left && shift_reg[`CCRB_LOAD_BIT]);
  c_pending_then_load: cover property ((wr_left && !shift_reg[`CCRB_LOAD_BIT]) ##[1:500]
    (wr_right && shift_reg[`CCRB_LOAD_BIT]));
  c_silence_done: cover property (silence && ramp_reg == 8'h0);
  c_format_write: cover property (wr_format);
  c_short_word: cover property (stb_rise && count_reg != word_len);
endmodule

// >>> ccrb_host_model.sv
`timescale 1ns/1ps
module ccrb_host_model (
  // clock
  clk,
  // serial control link
  shift_clk,
  ser_data,
  latch
);
  input wire logic clk;
  output logic shift_clk;
  output logic ser_data;
  output logic latch;
  // ****************************************
  // host side of the three-wire link
  // ****************************************
  initial begin
    shift_clk = 1'b0;
    ser_data = 1'b0;
    latch = 1'b0;
  end
  // msb first; shift clock idles low between words
  // phases are 4 clk so the device's 3-clk sampling is never marginal
  task automatic send(input logic [15:0] w, input int nbits);
    for (int i = 15; i > 15 - nbits; i--) begin
      @(negedge clk);
      ser_data = w[i];
      repeat (4) @(negedge clk);
      shift_clk = 1'b1;
      repeat (4) @(negedge clk);
      shift_clk = 1'b0;
    end
    // hold time is over, so the line must not keep looking valid
    ser_data = ~ser_data;
    repeat (4) @(negedge clk);
    latch = 1'b1;
    repeat (4) @(negedge clk);
    latch = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule

// >>> ccrb_params.svh
`ifndef CCRB_PARAMS_SVH
`define CCRB_PARAMS_SVH
// ****************************************
// word layout
// ****************************************
`define CCRB_WORD_BITS 16
`define CCRB_SEL_HI 10
`define CCRB_SEL_LO 9
`define CCRB_RES_HI 15
`define CCRB_RES_LO 11
`define CCRB_SEL_LEFT 2'h0
`define CCRB_SEL_RIGHT 2'h1
`define CCRB_SEL_GENERAL 2'h2
`define CCRB_SEL_FORMAT 2'h3
`define CCRB_LOAD_BIT 8
`define CCRB_CODE_HI 7
`define CCRB_CODE_LO 0
// general control word bits
`define CCRB_ADC_PD_BIT 8
`define CCRB_HPF_SKIP_BIT 7
`define CCRB_DAC_PD_BIT 6
`define CCRB_SHARED_BIT 5
`define CCRB_ZERO_DET_BIT 4
`define CCRB_OUT_DIS_BIT 3
`define CCRB_DEEMPH_HI 2
`define CCRB_DEEMPH_LO 1
`define CCRB_SILENCE_BIT 0
// format word bits
`define CCRB_LOOPBACK_BIT 5
`define CCRB_FMT_HI 3
`define CCRB_FMT_LO 2
`define CCRB_POLARITY_BIT 1
// ****************************************
// reset values
// ****************************************
`define CCRB_GAIN_RESET 8'hff
`define CCRB_LEFT_RESET 16'h00ff
`define CCRB_RIGHT_RESET 16'h02ff
`define CCRB_GENERAL_RESET 16'h0402
`define CCRB_FORMAT_RESET 16'h0600
// applied fields at reset: de-emphasis off, everything else clear
`define CCRB_CTRL_RESET 13'h0020
// ****************************************
// timing
// ****************************************
`define CCRB_RAMP_STEP_NS 10240
`define CCRB_CLK_NS 40
`define CCRB_RAMP_CYCLES (`CCRB_RAMP_STEP_NS / `CCRB_CLK_NS)
`endif

// >>> ccrb_pkg.sv
package ccrb_pkg;
  typedef struct packed {
    logic [7:0] left_level;
    logic [7:0] right_level;
  } ccrb_gain_s;
  typedef struct packed {
    logic adc_power_down;
    logic hpf_skip;
    logic dac_power_down;
    logic shared_gain_mode;
    logic zero_detect_enable;
    logic output_disable;
    logic [1:0] deemphasis_select;
    logic soft_silence;
    logic loopback_enable;
    logic [1:0] audio_format;
    logic frame_polarity;
  } ccrb_ctrl_s;
endpackage

// >>> tb_codec_control_register_bank.sv
`timescale 1ns/1ps
module tb_codec_control_register_bank;
  import ccrb_pkg::*;
  logic clk;
  logic reset;
  logic control_shift_clock;
  logic control_serial_data;
  logic latch_strobe;
  ccrb_gain_s gain_out;
  ccrb_ctrl_s ctrl_out;
  logic word_taken;
  int err_count;
  int samples_checked;
  int ramp_wait;
  logic [8:0] gen9;
  logic [3:0] fmt4;
  logic [15:0] gw [3];
  // ****************************************
  // clock, design and host
  // ****************************************
  initial clk = 1'b0;
  always #20 clk = ~clk;
  ccrb_codec_control_register_bank u_dut (.clk(clk), .reset(reset),
    .control_shift_clock(control_shift_clock), .control_serial_data(control_serial_data),
    .latch_strobe(latch_strobe), .gain_out(gain_out), .ctrl_out(ctrl_out),
    .word_taken(word_taken));
  ccrb_host_model u_host (.clk(clk), .shift_clk(control_shift_clock),
    .ser_data(control_serial_data), .latch(latch_strobe));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  // the window outlasts one word, so the pulses seen are counted and compared with taken
  task automatic wr(input logic [15:0] w, input int nbits, input logic [15:0] taken);
    int seen;
    seen = 0;
    fork
      u_host.send(w, nbits);
      for (int i = 0; i < 400; i++) begin
        @(posedge clk);
        #1;
        if (word_taken === 1'b1) seen++;
      end
    join
    chk("word_taken", 16'(seen), taken);
  endtask
  task automatic ctl();
    chk("ctrl_out", 16'(ctrl_out), {3'h0, gen9, fmt4});
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    err_count = 0;
    samples_checked = 0;
    reset = 1'b1;
    gen9 = 9'h002;
    fmt4 = 4'h0;
    gw = '{16'h05ca, 16'h0434, 16'h0402};
    repeat (12) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk("gain_out", gain_out, 16'hffff);
    ctl();
    $display("test reset done");
    foreach (gw[i]) begin
      wr(gw[i], 16, 16'h1);
      gen9 = gw[i][8:0];
      ctl();
    end
    wr(16'h062e, 16, 16'h1);
    fmt4 = 4'hf;
    ctl();
    $display("test control words done");
    wr(16'h0012, 16, 16'h1);
    chk("gain_out", gain_out, 16'hffff);
    wr(16'h0334, 16, 16'h1);
    chk("gain_out", gain_out, 16'h1234);
    wr(16'h0156, 16, 16'h1);
    chk("gain_out", gain_out, 16'h5634);
    wr(16'h0081, 16, 16'h1);
    chk("gain_out", gain_out, 16'h5634);
    wr(16'h0300, 16, 16'h1);
    chk("gain_out", gain_out, 16'h8100);
    $display("test gain load done");
    wr(16'h0422, 16, 16'h1);
    gen9 = 9'h022;
    ctl();
    chk("gain_out", gain_out, 16'h8181);
    $display("test shared gain done");
    wr(16'h05ff, 12, 16'h0);
    ctl();
    wr(16'h0402, 16, 16'h1);
    gen9 = 9'h002;
    ctl();
    chk("gain_out", gain_out, 16'h8100);
    $display("test short word done");
    // full ramp is 255 steps of 256 clk; an instant drop would be a click
    wr(16'h0403, 16, 16'h1);
    gen9 = 9'h003;
    ctl();
    ramp_wait = 0;
    while (gain_out !== 16'h0000 && ramp_wait < 70000) begin
      @(negedge clk);
      ramp_wait++;
    end
    chk("gain_out", gain_out, 16'h0000);
    chk("silence_ramp", 16'(ramp_wait > 60000), 16'h1);
    $display("test soft silence done");
    results();
  end
endmodule
